// ==== design/uhp_pkg.sv ====
package uhp_pkg;
   // Clock and frame timing.
   localparam int CLK_PERIOD_NS = 50;
   localparam int FRAME_NS = 1_000_000;
   localparam int FRAME_CYC = (FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Register indices; the byte address is four times the index.
   localparam logic [11:0] IDX_CTRL = 12'h00c;
   localparam logic [11:0] IDX_INTERVAL = 12'h103;
   localparam logic [11:0] IDX_CLEAR = 12'h104;
   localparam logic [11:0] IDX_SETUP = 12'h105;
   localparam logic [11:0] IDX_STATUS = 12'h106;
   localparam logic [11:0] IDX_PROTECT = 12'h107;
   localparam logic [15:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [15:0] ADDR_INTERVAL = {2'h0, IDX_INTERVAL, 2'h0};
   localparam logic [15:0] ADDR_CLEAR = {2'h0, IDX_CLEAR, 2'h0};
   localparam logic [15:0] ADDR_SETUP = {2'h0, IDX_SETUP, 2'h0};
   localparam logic [15:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [15:0] ADDR_PROTECT = {2'h0, IDX_PROTECT, 2'h0};
   // Pipe control word fields.
   localparam int MAXF_LSB = 12;
   localparam int EP_LSB = 8;
   localparam int DADDR_LSB = 0;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [7:0] INTERVAL_RST = 8'h00;
   localparam logic [5:0] SETUP_RST = 6'h00;
   // Setup register fields.
   localparam int SET_ON = 0;
   localparam int SET_KIND_LSB = 1;
   localparam int SET_TOK_LSB = 4;
   // Flag clear and status bit positions.
   localparam int FLG_CRC = 0;
   localparam int FLG_FLOW = 1;
   localparam int FLG_FROZEN = 2;
   localparam int FLG_WAKE = 3;
   localparam int ST_SYNCBUSY = 4;
   localparam int ST_ERR_LSB = 8;
   // Access cycles for the synchronised pipe control word and for the other registers.
   localparam logic [1:0] SYNC_CYC = 2'h3;
   localparam logic [1:0] PLAIN_CYC = 2'h1;
   // Largest isochronous exponent that the frame counter can hold.
   localparam logic [7:0] ISO_EXP_MAX = 8'h0f;
   localparam logic [1:0] TOK_OUT = 2'h2;
   localparam logic [1:0] TOK_RSVD = 2'h3;
   typedef enum logic [2:0] {
      UHP_KIND_OFF = 3'b000,
      UHP_KIND_CTRL = 3'b001,
      UHP_KIND_ISO = 3'b010,
      UHP_KIND_BULK = 3'b011,
      UHP_KIND_INT = 3'b100,
      UHP_KIND_EXT = 3'b101
   } uhp_kind_t;
endpackage

// ==== design/uhp_poll_if.sv ====
interface uhp_poll_if;
   logic frame_tick;
   logic [2:0] pipe_kind;
   logic [7:0] interval;
   logic pending;
   logic hs_done;
   logic hs_nyet;
   logic fire;
   modport ctl (output frame_tick, pipe_kind, interval, pending, hs_done, hs_nyet, input fire);
   modport poll (input frame_tick, pipe_kind, interval, pending, hs_done, hs_nyet, output fire);
endinterface // uhp_poll_if

// ==== design/uhp_poll.sv ====
module uhp_poll (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Link to the pipe controller.
   uhp_poll_if.poll pif
);
   import uhp_pkg::*;

   logic [15:0] frames_r, frames_nxt;
   logic wait_r, wait_nxt;
   logic retry_r, retry_nxt;
   logic fire_r, fire_nxt;
   logic [15:0] period;
   logic due;

   assign pif.fire = fire_r;

   always_comb begin
      period = {8'h00, pif.interval};
      if (pif.pipe_kind == UHP_KIND_ISO) begin
         // Exponents above the counter width saturate to the longest period.
         period = 16'h0001 << ((pif.interval > ISO_EXP_MAX) ? ISO_EXP_MAX[3:0]
                                                           : pif.interval[3:0]);
      end
      if (pif.pipe_kind == UHP_KIND_EXT) begin
         due = retry_r && (frames_r >= 16'h0001);
      end else if (pif.interval == 8'h00) begin
         due = 1'b1;
      end else begin
         due = frames_r >= period;
      end
      fire_nxt = pif.pending && !wait_r && !fire_r && due
                 && (pif.pipe_kind != UHP_KIND_OFF);
      frames_nxt = frames_r;
      if (fire_nxt) begin
         frames_nxt = 16'h0000;
      end else if (pif.frame_tick && frames_r != 16'hffff) begin
         frames_nxt = frames_r + 16'h0001;
      end
      wait_nxt = wait_r;
      if (fire_nxt) begin
         wait_nxt = 1'b1;
      end else if (pif.hs_done) begin
         wait_nxt = 1'b0;
      end
      retry_nxt = retry_r;
      if (pif.hs_nyet) begin
         retry_nxt = 1'b1;
         frames_nxt = 16'h0000;
      end else if (fire_nxt || !pif.pending) begin
         retry_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frames_r <= 16'hffff;
         wait_r <= 1'b0;
         retry_r <= 1'b0;
         fire_r <= 1'b0;
      end else begin
         frames_r <= frames_nxt;
         wait_r <= wait_nxt;
         retry_r <= retry_nxt;
         fire_r <= fire_nxt;
      end
   end

   ext_nyet_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      fire_r && $past(pif.pipe_kind) == UHP_KIND_EXT |-> $past(retry_r))
      else $error("extended pipe fired without a pending nyet retry");
   nonzero_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      fire_r && $past(pif.pipe_kind) != UHP_KIND_EXT && $past(pif.interval) != 8'h00
      |-> $past(frames_r) >= $past(period))
      else $error("out token fired before the interval elapsed");
endmodule // uhp_poll

// ==== design/uhp_pipe.sv ====
// Design decision made here: the APB slave port.
module uhp_pipe #(
   parameter int FRAME_CYCLES = uhp_pkg::FRAME_CYC
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Events from the USB engine.
   input wire logic usb_reset_sent,
   input wire logic tx_pending,
   input wire logic hs_ack,
   input wire logic hs_nak,
   input wire logic hs_nyet,
   input wire logic txn_error,
   input wire logic iso_overrun,
   input wire logic iso_underflow,
   input wire logic iso_crc_error,
   input wire logic wake_evt,
   // Requests and pipe settings to the USB engine.
   output logic out_token_go,
   output logic [1:0] token_select,
   output logic token_valid,
   output logic [3:0] endpoint_index,
   output logic [6:0] device_addr_field,
   output logic pipe_frozen,
   output logic sleep_exit_irq
);
   import uhp_pkg::*;

   localparam int DIV_W = $clog2(FRAME_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FRAME_CYCLES - 1);

   // Bus state.
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [1:0] wcnt_r, wcnt_nxt;
   // Pipe state.
   logic [15:0] ctrl_r, ctrl_nxt;
   logic [7:0] intv_r, intv_nxt;
   logic [5:0] setup_r, setup_nxt;
   logic prot_r, prot_nxt;
   logic crc_r, crc_nxt;
   logic flow_r, flow_nxt;
   logic frozen_r, frozen_nxt;
   logic [3:0] err_r, err_nxt;
   logic wake_r, wake_nxt;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic tick_r, tick_nxt;
   logic go_r, go_nxt;
   logic tokv_r, tokv_nxt;
   // Decode.
   logic acc, done, wr_ok;
   logic is_ctrl, is_intv, is_clr, is_setup, is_stat, is_prot, prot_hit, mapped;
   logic [1:0] need;
   logic [31:0] rd;
   logic [2:0] kind;
   logic pipe_on;
   logic [3:0] err_inc;
   logic [3:0] max_fault_count;

   uhp_poll_if pif ();

   uhp_poll u_poll (
      .pclk(pclk),
      .presetn(presetn),
      .pif(pif)
   );

   assign kind = setup_r[SET_KIND_LSB +: 3];
   assign pipe_on = setup_r[SET_ON];
   assign max_fault_count = ctrl_r[MAXF_LSB +: 4];
   assign pif.frame_tick = tick_r;
   assign pif.pipe_kind = kind;
   assign pif.interval = intv_r;
   assign pif.hs_done = hs_ack || hs_nak || hs_nyet || txn_error;
   assign pif.hs_nyet = hs_nyet && kind == UHP_KIND_EXT;
   // The token field only gates OUT polling when the pipe is not extended.
   assign pif.pending = tx_pending && pipe_on && !frozen_r
                        && (kind == UHP_KIND_EXT || setup_r[SET_TOK_LSB +: 2] == TOK_OUT);

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign out_token_go = go_r;
   assign token_select = setup_r[SET_TOK_LSB +: 2];
   assign token_valid = tokv_r;
   assign endpoint_index = ctrl_r[EP_LSB +: 4];
   assign device_addr_field = ctrl_r[DADDR_LSB +: 7];
   assign pipe_frozen = frozen_r;
   assign sleep_exit_irq = wake_r;

   // Bus slave: the control word takes extra access cycles for its domain crossing.
   always_comb begin
      acc = psel && penable && !pready_r;
      done = psel && penable && pready_r;
      is_ctrl = paddr == ADDR_CTRL;
      is_intv = paddr == ADDR_INTERVAL;
      is_clr = paddr == ADDR_CLEAR;
      is_setup = paddr == ADDR_SETUP;
      is_stat = paddr == ADDR_STATUS;
      is_prot = paddr == ADDR_PROTECT;
      prot_hit = is_ctrl || is_intv || is_clr || is_setup;
      mapped = prot_hit || is_stat || is_prot;
      need = is_ctrl ? SYNC_CYC : PLAIN_CYC;
      rd = 32'h0000_0000;
      if (is_ctrl) begin
         rd = {16'h0000, ctrl_r};
      end else if (is_intv) begin
         rd = {24'h00_0000, intv_r};
      end else if (is_setup) begin
         rd = {26'h000_0000, setup_r};
      end else if (is_prot) begin
         rd = {31'h0000_0000, prot_r};
      end else if (is_stat) begin
         rd[FLG_CRC] = crc_r;
         rd[FLG_FLOW] = flow_r;
         rd[FLG_FROZEN] = frozen_r;
         rd[FLG_WAKE] = wake_r;
         rd[ST_SYNCBUSY] = wcnt_r != 2'h0;
         rd[ST_ERR_LSB +: 4] = err_r;
      end
      wcnt_nxt = wcnt_r;
      pready_nxt = 1'b0;
      pslverr_nxt = pslverr_r;
      prdata_nxt = prdata_r;
      if (acc) begin
         if (wcnt_r == need - 2'h1) begin
            wcnt_nxt = 2'h0;
            pready_nxt = 1'b1;
            pslverr_nxt = !mapped || (pwrite && prot_r && prot_hit);
            prdata_nxt = pwrite ? 32'h0000_0000 : rd;
         end else begin
            wcnt_nxt = wcnt_r + 2'h1;
         end
      end
      wr_ok = done && pwrite && !pslverr_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         wcnt_r <= 2'h0;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
         wcnt_r <= wcnt_nxt;
      end
   end

   // Pipe configuration, flags and error counting.
   always_comb begin
      ctrl_nxt = ctrl_r;
      setup_nxt = setup_r;
      prot_nxt = prot_r;
      intv_nxt = intv_r;
      if (wr_ok && is_ctrl) begin
         ctrl_nxt = pwdata[15:0];
      end
      if (wr_ok && is_setup) begin
         setup_nxt = pwdata[5:0];
      end
      if (wr_ok && is_prot) begin
         prot_nxt = pwdata[0];
      end
      if (usb_reset_sent || !pipe_on) begin
         intv_nxt = INTERVAL_RST;
      end else if (wr_ok && is_intv) begin
         intv_nxt = pwdata[7:0];
      end
      // Hardware events win over a clear written in the same cycle.
      crc_nxt = crc_r;
      if (wr_ok && is_clr && pwdata[FLG_CRC]) begin
         crc_nxt = 1'b0;
      end
      if (iso_crc_error && kind == UHP_KIND_ISO) begin
         crc_nxt = 1'b1;
      end
      flow_nxt = flow_r;
      if (wr_ok && is_clr && pwdata[FLG_FLOW]) begin
         flow_nxt = 1'b0;
      end
      if (hs_nak && kind != UHP_KIND_ISO) begin
         flow_nxt = 1'b1;
      end
      if (kind == UHP_KIND_ISO && (iso_overrun || iso_underflow)) begin
         flow_nxt = 1'b1;
      end
      err_inc = (err_r == 4'hf) ? err_r : err_r + 4'h1;
      err_nxt = err_r;
      frozen_nxt = frozen_r;
      if (wr_ok && is_clr && pwdata[FLG_FROZEN]) begin
         frozen_nxt = 1'b0;
      end
      if (usb_reset_sent) begin
         err_nxt = 4'h0;
      end else if (txn_error) begin
         err_nxt = err_inc;
         if (err_inc >= max_fault_count) begin
            frozen_nxt = 1'b1;
         end
      end else if (hs_ack) begin
         err_nxt = 4'h0;
      end
      wake_nxt = wake_r && !(wr_ok && is_clr && pwdata[FLG_WAKE]);
      div_nxt = (div_r == DIV_LAST) ? '0 : div_r + DIV_W'(1);
      tick_nxt = div_r == DIV_LAST;
      go_nxt = pif.fire;
      tokv_nxt = kind != UHP_KIND_EXT && setup_r[SET_TOK_LSB +: 2] != TOK_RSVD;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         setup_r <= SETUP_RST;
         prot_r <= 1'b0;
         intv_r <= INTERVAL_RST;
         crc_r <= 1'b0;
         flow_r <= 1'b0;
         err_r <= 4'h0;
         frozen_r <= 1'b0;
         div_r <= '0;
         tick_r <= 1'b0;
         go_r <= 1'b0;
         tokv_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         setup_r <= setup_nxt;
         prot_r <= prot_nxt;
         intv_r <= intv_nxt;
         crc_r <= crc_nxt;
         flow_r <= flow_nxt;
         err_r <= err_nxt;
         frozen_r <= frozen_nxt;
         div_r <= div_nxt;
         tick_r <= tick_nxt;
         go_r <= go_nxt;
         tokv_r <= tokv_nxt;
      end
   end

   // The wake event sets this flag with no clock edge, so it can rouse a stopped system.
   always_ff @(posedge pclk or negedge presetn or posedge wake_evt) begin
      if (!presetn) begin
         wake_r <= 1'b0;
      end else if (wake_evt) begin
         wake_r <= 1'b1;
      end else begin
         wake_r <= wake_nxt;
      end
   end

   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready_r |=> !pready_r)
      else $error("pready held for more than one cycle");
   sync_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready_r && is_ctrl && wcnt_r == 2'h0 |=> !pready_r ##1 !pready_r)
      else $error("control word answered before the sync cycles");
   protect_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      done && pwrite && is_ctrl && prot_r && !usb_reset_sent |=> $stable(ctrl_r))
      else $error("protected control word changed on a write");
   intv_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      usb_reset_sent || !pipe_on |=> intv_r == 8'h00)
      else $error("interval not cleared on reset or pipe off");
   nak_flow_a: assert property (@(posedge pclk) disable iff (!presetn)
      hs_nak && kind != UHP_KIND_ISO |=> flow_r)
      else $error("nak did not set the flow fault flag");
   iso_flow_a: assert property (@(posedge pclk) disable iff (!presetn)
      kind == UHP_KIND_ISO && (iso_overrun || iso_underflow) |=> flow_r)
      else $error("iso overrun or underflow did not set the flow flag");
   crc_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(crc_r) |-> $past(iso_crc_error) && $past(kind) == UHP_KIND_ISO)
      else $error("checksum flag set without an iso crc error");
   freeze_max_a: assert property (@(posedge pclk) disable iff (!presetn)
      txn_error && !usb_reset_sent && err_inc >= max_fault_count |=> frozen_r)
      else $error("pipe not frozen at the maximum error count");
   err_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      usb_reset_sent |=> err_r == 4'h0)
      else $error("error count not cleared by usb reset");
   wake_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wake_evt |-> ##1 wake_r)
      else $error("wake event did not raise the wake interrupt");
   token_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
      kind == UHP_KIND_EXT |=> !tokv_r)
      else $error("token marked valid on an extended pipe");
   // Bus answers and flag upkeep.
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      done && !mapped |-> pslverr_r)
      else $error("unmapped access answered without an error");
   unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      done && !pwrite && !mapped |-> prdata_r == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      done && pwrite && is_ctrl && !pslverr_r |=> ctrl_r == $past(pwdata[15:0]))
      else $error("accepted control word write did not land");
   plain_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready_r && !is_ctrl |=> pready_r)
      else $error("plain register not answered after one access cycle");
   intv_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && is_intv && pipe_on && !usb_reset_sent |=> intv_r == $past(pwdata[7:0]))
      else $error("interval write on an enabled pipe did not land");
   crc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && is_clr && pwdata[FLG_CRC] && !iso_crc_error |=> !crc_r)
      else $error("checksum flag survived its clear");
   flow_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && is_clr && pwdata[FLG_FLOW] && !hs_nak && !iso_overrun && !iso_underflow |=> !flow_r)
      else $error("flow fault flag survived its clear");
   wake_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      wake_r && !(wr_ok && is_clr && pwdata[FLG_WAKE]) |=> wake_r)
      else $error("wake interrupt dropped without a clear");
   err_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      txn_error && !usb_reset_sent && err_r != 4'hf |=> err_r == $past(err_r) + 4'h1)
      else $error("error count did not step on a transaction error");
   ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      hs_ack && !txn_error |=> err_r == 4'h0)
      else $error("error count not cleared by an ack");
   frozen_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      frozen_r && $past(frozen_r, 2) |-> !go_r)
      else $error("frozen pipe requested a token");
endmodule // uhp_pipe

// ==== verif/uhp_usb_peer.sv ====
module uhp_usb_peer (
   // Clock.
   input wire logic pclk,
   // Token from the host and the reply that the bench chooses.
   input wire logic out_token_go,
   input wire logic [1:0] reply_kind,
   input wire logic [3:0] reply_wait,
   // Handshake back to the host.
   output logic hs_ack,
   output logic hs_nak,
   output logic hs_nyet,
   output logic txn_error
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = -1;
   logic [3:0] hs_r = 4'h0;

   // One handshake answers each token; a slow reply is a larger reply_wait.
   assign {hs_ack, hs_nak, hs_nyet, txn_error} = hs_r;
   always @(posedge pclk) begin
      hs_r <= 4'h0;
      if (out_token_go === 1'b1) begin
         cnt <= reply_wait;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (cnt == 0) begin
         cnt <= -1;
         hs_r <= 4'h8 >> reply_kind;
      end
   end
endmodule // uhp_usb_peer

// ==== verif/usb_host_pipe_control_tb_top.sv ====
module usb_host_pipe_control_tb_top;
   import uhp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FR = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, usb_reset_sent = 1'b0, tx_pending = 1'b0;
   logic hs_ack, hs_nak, hs_nyet, txn_error, iso_overrun = 1'b0, iso_underflow = 1'b0;
   logic iso_crc_error = 1'b0, wake_evt = 1'b0, out_token_go, token_valid, pipe_frozen;
   logic sleep_exit_irq;
   logic [1:0] token_select, reply_kind = 2'h1;
   logic [3:0] endpoint_index, reply_wait = 4'h2;
   logic [6:0] device_addr_field;
   int err_total = 0, comparisons = 0, last_n, n;

   uhp_pipe #(.FRAME_CYCLES(FR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_reset_sent(usb_reset_sent),
      .tx_pending(tx_pending), .hs_ack(hs_ack), .hs_nak(hs_nak), .hs_nyet(hs_nyet),
      .txn_error(txn_error), .iso_overrun(iso_overrun), .iso_underflow(iso_underflow),
      .iso_crc_error(iso_crc_error), .wake_evt(wake_evt), .out_token_go(out_token_go),
      .token_select(token_select), .token_valid(token_valid),
      .endpoint_index(endpoint_index), .device_addr_field(device_addr_field),
      .pipe_frozen(pipe_frozen), .sleep_exit_irq(sleep_exit_irq));
   uhp_usb_peer peer (.pclk(pclk), .out_token_go(out_token_go), .reply_kind(reply_kind),
      .reply_wait(reply_wait), .hs_ack(hs_ack), .hs_nak(hs_nak), .hs_nyet(hs_nyet),
      .txn_error(txn_error));

   always #25 pclk = ~pclk;

   task automatic tally_and_finish();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Every transfer opens just after an edge and idles one cycle afterwards.
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      last_n = 0;
      do begin
         @(posedge pclk);
         last_n++;
      end while (pready !== 1'b1 && last_n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (last_n >= 50) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
      apb(1'b1, a, d);
      chk({31'h0, e}, {31'h0, ee});
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask

   // One-cycle event pulse; the mask bits are usb reset, crc, overrun, underflow.
   task automatic pulse(input logic [3:0] m);
      @(posedge pclk);
      {usb_reset_sent, iso_crc_error, iso_overrun, iso_underflow} <= m;
      @(posedge pclk);
      {usb_reset_sent, iso_crc_error, iso_overrun, iso_underflow} <= 4'h0;
   endtask

   // Returns the number of cycles until the next token request.
   task automatic wait_go(output int k);
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (out_token_go !== 1'b1 && k < 400);
      if (k >= 400) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL, 32'h0);
      chk(last_n, 4);
      rd(ADDR_INTERVAL, 32'h0);
      wr(ADDR_CTRL, 32'h2592, 1'b0);
      rd(ADDR_CTRL, 32'h2592);
      chk({28'h0, endpoint_index}, 32'h5);
      chk({25'h0, device_addr_field}, 32'h12);
      apb(1'b0, 16'h0200, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(ADDR_PROTECT, 32'h1, 1'b0);
      wr(ADDR_CTRL, 32'h0, 1'b1);
      rd(ADDR_CTRL, 32'h2592);
      wr(ADDR_PROTECT, 32'h0, 1'b0);
      wr(ADDR_INTERVAL, 32'h5, 1'b0);
      rd(ADDR_INTERVAL, 32'h0);
      wr(ADDR_SETUP, 32'h37, 1'b0);
      cyc(2);
      chk({31'h0, token_valid}, 32'h0);
      wr(ADDR_SETUP, 32'h2b, 1'b0);
      cyc(2);
      chk({31'h0, token_valid}, 32'h0);
      wr(ADDR_SETUP, 32'h27, 1'b0);
      cyc(2);
      chk({30'h0, token_select, token_valid}, 32'h5);
      // Isochronous fault flags, each cleared again by software.
      wr(ADDR_SETUP, 32'h25, 1'b0);
      wr(ADDR_CLEAR, 32'hf, 1'b0);
      pulse(4'h4);
      rd(ADDR_STATUS, 32'h1);
      wr(ADDR_CLEAR, 32'h1, 1'b0);
      pulse(4'h2);
      rd(ADDR_STATUS, 32'h2);
      wr(ADDR_CLEAR, 32'h2, 1'b0);
      pulse(4'h1);
      rd(ADDR_STATUS, 32'h2);
      wr(ADDR_CLEAR, 32'h2, 1'b0);
      rd(ADDR_STATUS, 32'h0);
      // Bulk, then isochronous, polling with the peripheral refusing every token.
      wr(ADDR_SETUP, 32'h27, 1'b0);
      @(posedge pclk);
      tx_pending <= 1'b1;
      wait_go(n);
      wait_go(n);
      chk({31'h0, n <= 8}, 32'h1);
      rd(ADDR_STATUS, 32'h2);
      wr(ADDR_INTERVAL, 32'h2, 1'b0);
      wait_go(n);
      wait_go(n);
      chk({31'h0, n > FR && n <= 2 * FR + 6}, 32'h1);
      wr(ADDR_SETUP, 32'h25, 1'b0);
      wait_go(n);
      wait_go(n);
      chk({31'h0, n > 3 * FR && n <= 4 * FR + 6}, 32'h1);
      // Extended pipe: a slow NYET to an iso token lands after the switch and arms the retry.
      @(posedge pclk);
      tx_pending <= 1'b0;
      reply_kind <= 2'h2;
      reply_wait <= 4'hf;
      cyc(8);
      wr(ADDR_INTERVAL, 32'h0, 1'b0);
      @(posedge pclk);
      tx_pending <= 1'b1;
      wait_go(n);
      wr(ADDR_SETUP, 32'h2b, 1'b0);
      reply_wait <= 4'h2;
      wait_go(n);
      wait_go(n);
      // NYET is seen five edges after the token, then up to one frame, then two register stages.
      chk({31'h0, n > 7 && n <= FR + 7}, 32'h1);
      @(posedge pclk);
      reply_kind <= 2'h1;
      n = 0;
      repeat (3 * FR) begin
         @(negedge pclk);
         n += int'(out_token_go === 1'b1);
      end
      chk(n, 0);
      // Errors up to the limit of two freeze the pipe.
      @(posedge pclk);
      tx_pending <= 1'b0;
      reply_kind <= 2'h3;
      pulse(4'h8);
      wr(ADDR_SETUP, 32'h27, 1'b0);
      wr(ADDR_CLEAR, 32'hf, 1'b0);
      @(posedge pclk);
      tx_pending <= 1'b1;
      wait_go(n);
      wait_go(n);
      cyc(8);
      chk({31'h0, pipe_frozen}, 32'h1);
      @(posedge pclk);
      tx_pending <= 1'b0;
      rd(ADDR_STATUS, 32'h204);
      wr(ADDR_CLEAR, 32'h4, 1'b0);
      wr(ADDR_INTERVAL, 32'h3, 1'b0);
      rd(ADDR_INTERVAL, 32'h3);
      pulse(4'h8);
      rd(ADDR_STATUS, 32'h0);
      rd(ADDR_INTERVAL, 32'h0);
      // The wake flag must set before the next clock edge arrives.
      @(posedge pclk);
      wake_evt <= 1'b1;
      #5;
      chk({31'h0, sleep_exit_irq}, 32'h1);
      @(posedge pclk);
      wake_evt <= 1'b0;
      wr(ADDR_CLEAR, 32'h8, 1'b0);
      cyc(1);
      chk({31'h0, sleep_exit_irq}, 32'h0);
      tally_and_finish();
   end
endmodule // usb_host_pipe_control_tb_top
